// ===== hw/cmr_pkg.sv
// constants and types shared by the config and memory route decoder
package cmr_pkg;
    localparam int NPORT = 6;
    localparam int NOWN = 12;
    localparam int NPREG = 9;

    // own register word indices; byte address is four times the index
    localparam logic [3:0] OI_BUS = 4'h0;
    localparam logic [3:0] OI_CMD = 4'h1;
    localparam logic [3:0] OI_CTL = 4'h2;
    localparam logic [3:0] OI_MEM = 4'h3;
    localparam logic [3:0] OI_PFBL = 4'h4;
    localparam logic [3:0] OI_PFBH = 4'h5;
    localparam logic [3:0] OI_PFLL = 4'h6;
    localparam logic [3:0] OI_PFLH = 4'h7;
    localparam logic [3:0] OI_STAT = 4'h8;
    localparam logic [3:0] OI_ROOT = 4'h9;
    localparam logic [3:0] OI_UPPER = 4'ha;
    localparam logic [3:0] OI_ERR = 4'hb;

    // per-port table word indices, block n+1 of 64 bytes holds port n
    localparam logic [3:0] PI_STATE = 4'h0;
    localparam logic [3:0] PI_CMD = 4'h1;
    localparam logic [3:0] PI_CTL = 4'h2;
    localparam logic [3:0] PI_BUS = 4'h3;
    localparam logic [3:0] PI_MEM = 4'h4;
    localparam logic [3:0] PI_PFBL = 4'h5;
    localparam logic [3:0] PI_PFBH = 4'h6;
    localparam logic [3:0] PI_PFLL = 4'h7;
    localparam logic [3:0] PI_PFLH = 4'h8;
    localparam logic [5:0] OWN_BLOCK = 6'h00;

    // field positions
    localparam int ST_TBLEN = 4;
    localparam int ST_SHORT = 5;
    localparam int CMD_MEMEN = 1;
    localparam int CMD_MASTER = 2;
    localparam int CTL_VGA = 3;
    localparam int STAT_NOTGT = 13;
    localparam int ERR_OVL = 0;
    localparam int BUS_PRI = 0;
    localparam int BUS_SEC = 8;
    localparam int BUS_SUB = 16;

    localparam logic [31:0] RST_VAL = 32'h0000_0000;

    localparam logic [31:0] OWN_MASK [NOWN] = '{
        32'h00ff_ffff, 32'h0000_0004, 32'h0000_0008, 32'hfff0_fff0,
        32'hfff0_0000, 32'hffff_ffff, 32'hfff0_0000, 32'hffff_ffff,
        32'h0000_2000, 32'h0000_0007, 32'h0000_3fff, 32'h0000_0001};
    localparam logic [31:0] PRT_MASK [NPREG] = '{
        32'h0000_0030, 32'h0000_0002, 32'h0000_0008, 32'h00ff_ffff,
        32'hfff0_fff0, 32'hfff0_0000, 32'hffff_ffff, 32'hfff0_0000,
        32'hffff_ffff};

    // configuration address layout within the 50-bit frame address
    localparam int CF_TYPE = 49;
    localparam int CF_BUS = 16;
    localparam int CF_DEV = 11;
    localparam int CF_FN = 8;
    localparam int CF_REG = 2;

    localparam logic [31:0] VGA_LO = 32'h000a_0000;
    localparam logic [31:0] VGA_HI = 32'h000b_ffff;

    localparam logic FT_NORMAL = 1'b0;
    localparam logic FT_SWFAIL = 1'b1;

    typedef enum logic [1:0] {
        RG_MEM32 = 2'b00,
        RG_MEM64 = 2'b01,
        RG_IO = 2'b10,
        RG_CFG = 2'b11
    } cmr_region_t;
endpackage

// ===== hw/cmr_route_decoder.sv
// routing decision for configuration and memory frames, with apb registers
// What this block does
// RQ1 - Offset bit 49 clear means Type0, set means Type1.
// RQ2 - Type0 accepted only from root; elsewhere software failure, no event.
// RQ3 - Type0 root writes update registers even when flagged with error.
// RQ4 - Root Type1 matching own secondary bus converts to Type0, bit 49 cleared.
// RQ5 - Converted frame goes to port equal device number when port eligible.
// RQ6 - No qualifying port: software failure, set no-target status flag.
// RQ7 - Downstream special-cycle write on secondary bus raises event, normal ack.
// RQ8 - Unconverted Type1 forwards where secondary < bus <= subordinate, eligible.
// RQ9 - No port bus decode: software failure, set no-target flag.
// RQ10 - Non-root Type1 forwarded only if special-cycle write, else failure.
// RQ11 - Upstream special cycle on primary bus: discard, normal, event.
// RQ12 - Else inclusive port range, then root if outside own range, else fail.
// RQ13 - Memory windows: 32-bit, 64-bit prefetchable, fixed video range.
// RQ14 - Port decode needs memory enable; upstream needs own bus-master enable.
// RQ15 - Root memory: positive decode, else failure, no-target and event.
// RQ16 - Non-root memory: port match, then inverse own decode to root, else fail.
// RQ17 - Fabric shares one value for address bits 63 to 50.
// RQ18 - 64-bit frames compare only against the prefetchable window.
// RQ19 - 32-bit frames have zero upper bits; also test 32-bit and video.
// RQ20 - The block never targets memory frames, only forwards them.
// RQ21 - Port state bits 4 and 5: table enable and shortcut enable.
// RQ22 - Shortcut enable excludes port from config decodes, not memory.
// RQ23 - Several matches pick lowest port and flag an overlap error.
// RQ24 - One decision per header: port, or failure with type and events.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module cmr_route_decoder
    import cmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hdrValid,
    input wire logic [2:0] hdrInPort,
    input wire logic [1:0] hdrRegion,
    input wire logic hdrWrite,
    input wire logic [49:0] hdrAddr,
    output logic rtValid,
    output logic rtForward,
    output logic [2:0] rtPort,
    output logic rtLocal,
    output logic rtFail,
    output logic rtFailType,
    output logic rtConvert,
    output logic [49:0] rtAddr,
    output logic evSpecial,
    output logic evRouteFail,
    output logic cfgOverlap
);
    logic [31:0] ownRegs_ff [NOWN];
    logic [31:0] portRegs_ff [NPORT][NPREG];
    logic [31:0] prdata_ff;
    logic rtValid_ff;
    logic rtForward_ff;
    logic rtLocal_ff;
    logic rtFail_ff;
    logic rtFailType_ff;
    logic rtConvert_ff;
    logic evSpecial_ff;
    logic evRouteFail_ff;
    logic [2:0] rtPort_ff;
    logic [49:0] rtAddr_ff;

    // apb decode
    wire [5:0] blk = paddr[11:6];
    wire [3:0] wIdx = paddr[5:2];
    wire [2:0] pIdx = 3'(blk - 6'h1);
    wire ownOk = (blk == OWN_BLOCK) && (wIdx < 4'(NOWN));
    wire portOk = (blk != OWN_BLOCK) && (blk <= 6'(NPORT))
        && (wIdx < 4'(NPREG));
    // unmapped or misaligned words read zero and raise an error
    wire addrBad = !(ownOk || portOk) || (paddr[1:0] != 2'b00);
    wire apbWr = psel && penable && pwrite && !addrBad;
    wire apbSetup = psel && !penable;
    wire [31:0] rdWord = addrBad ? 32'h0000_0000 :
        ownOk ? ownRegs_ff[wIdx] : portRegs_ff[pIdx][wIdx];

    // zero wait states; every access ends at its first access edge
    assign pready = 1'b1;
    assign pslverr = psel && penable && addrBad;
    assign prdata = prdata_ff;

    // own configuration fields
    wire [7:0] ownPri = ownRegs_ff[OI_BUS][BUS_PRI +: 8];
    wire [7:0] ownSec = ownRegs_ff[OI_BUS][BUS_SEC +: 8];
    wire [7:0] ownSub = ownRegs_ff[OI_BUS][BUS_SUB +: 8];
    wire ownMaster = ownRegs_ff[OI_CMD][CMD_MASTER];
    wire [2:0] rootPort = ownRegs_ff[OI_ROOT][2:0];
    wire [13:0] fabUpper = ownRegs_ff[OI_UPPER][13:0];

    // frame fields
    wire isType1 = hdrAddr[CF_TYPE]; // RQ1
    wire [7:0] cfBus = hdrAddr[CF_BUS +: 8];
    wire [4:0] cfDev = hdrAddr[CF_DEV +: 5];
    wire [2:0] cfFn = hdrAddr[CF_FN +: 3];
    wire [5:0] cfReg = hdrAddr[CF_REG +: 6];
    // root port number is programmable and resets to port 0
    wire fromRoot = hdrInPort == rootPort;
    wire spEnc = (cfReg == 6'h00) && (cfDev == 5'h1f)
        && (cfFn == 3'h7);
    // any write flavour counts, with or without ack or error
    wire isSpecial = spEnc && hdrWrite;
    wire is64 = hdrRegion == RG_MEM64;
    // upper bits of 64-bit frames come from the one fabric-wide value
    wire [63:0] addr64 = is64 ? {fabUpper, hdrAddr} // RQ17
        : {32'h0000_0000, hdrAddr[31:0]}; // RQ19

    function automatic logic winHit(
        input logic [63:0] a,
        input logic wide,
        input logic [31:0] mem,
        input logic [31:0] bl,
        input logic [31:0] bh,
        input logic [31:0] ll,
        input logic [31:0] lh,
        input logic vga
    );
        logic m32;
        logic pf;
        logic vg;
        m32 = !wide && (a[31:20] >= mem[15:4]) && (a[31:20] <= mem[31:20]);
        pf = (a[63:20] >= {bh, bl[31:20]}) && (a[63:20] <= {lh, ll[31:20]});
        vg = !wide && vga && (a[31:0] >= VGA_LO) && (a[31:0] <= VGA_HI);
        return m32 || pf || vg; // RQ13 RQ18
    endfunction

    function automatic logic [2:0] lowSel(input logic [NPORT-1:0] v);
        logic [2:0] s;
        s = 3'h0;
        for (int i = NPORT - 1; i >= 0; i--) begin
            if (v[i]) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // per-port decodes
    logic [NPORT-1:0] devHit;
    logic [NPORT-1:0] cfgRng;
    logic [NPORT-1:0] spRng;
    logic [NPORT-1:0] memHit;
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            wire [7:0] pSec = portRegs_ff[p][PI_BUS][BUS_SEC +: 8];
            wire [7:0] pSub = portRegs_ff[p][PI_BUS][BUS_SUB +: 8];
            wire tblEn = portRegs_ff[p][PI_STATE][ST_TBLEN]; // RQ21
            wire shortEn = portRegs_ff[p][PI_STATE][ST_SHORT]; // RQ21
            // shortcut only removes the port from config decodes
            wire elig = tblEn && !shortEn && (pSec != 8'h00)
                && (pSub != 8'h00); // RQ22
            assign devHit[p] = elig && (cfDev == 5'(p)); // RQ5
            assign cfgRng[p] = elig && (cfBus > pSec)
                && (cfBus <= pSub); // RQ8
            assign spRng[p] = elig && (cfBus >= pSec)
                && (cfBus <= pSub); // RQ12
            // the receiving port never decodes its own memory frame back
            assign memHit[p] = tblEn && (hdrInPort != 3'(p))
                && portRegs_ff[p][PI_CMD][CMD_MEMEN] // RQ14
                && winHit(addr64, is64, portRegs_ff[p][PI_MEM],
                    portRegs_ff[p][PI_PFBL], portRegs_ff[p][PI_PFBH],
                    portRegs_ff[p][PI_PFLL], portRegs_ff[p][PI_PFLH],
                    portRegs_ff[p][PI_CTL][CTL_VGA]);
        end
    endgenerate

    wire ownHit = winHit(addr64, is64, ownRegs_ff[OI_MEM],
        ownRegs_ff[OI_PFBL], ownRegs_ff[OI_PFBH], ownRegs_ff[OI_PFLL],
        ownRegs_ff[OI_PFLH], ownRegs_ff[OI_CTL][CTL_VGA]);
    // inverse bus decode: numbers outside this range go to the root
    wire ownBusIn = (cfBus >= ownSec) && (cfBus <= ownSub);
    wire [2:0] devPort = cfDev[2:0];
    // device numbers past the last port never qualify
    wire devOk = (cfDev < 5'(NPORT)) && devHit[devPort];
    // more than one bit set means overlapping tables
    wire cfgMulti = (cfgRng & (cfgRng - 6'h01)) != 6'h00;
    wire spMulti = (spRng & (spRng - 6'h01)) != 6'h00;
    wire memMulti = (memHit & (memHit - 6'h01)) != 6'h00;

    logic dFwd;
    logic dLocal;
    logic dFail;
    logic dFt;
    logic dConv;
    logic dEvS;
    logic dEvF;
    logic dNoTgt;
    logic dOvl;
    logic [2:0] dPort;

    // RQ24
    always_comb begin
        dFwd = 1'b0;
        dLocal = 1'b0;
        dFail = 1'b0;
        dFt = FT_NORMAL;
        dConv = 1'b0;
        dEvS = 1'b0;
        dEvF = 1'b0;
        dNoTgt = 1'b0;
        dOvl = 1'b0;
        dPort = rootPort;
        case (hdrRegion)
            RG_CFG: begin
                if (!isType1) begin
                    if (fromRoot) begin
                        // write error flag does not gate the access
                        dLocal = 1'b1; // RQ3
                    end else begin
                        dFail = 1'b1; // RQ2
                        dFt = FT_SWFAIL;
                    end
                end else if (fromRoot) begin
                    if (cfBus == ownSec) begin
                        dConv = 1'b1; // RQ4
                        if (isSpecial) begin
                            dEvS = 1'b1; // RQ7
                        end else if (devOk) begin
                            dFwd = 1'b1; // RQ5
                            dPort = devPort;
                        end else begin
                            dFail = 1'b1; // RQ6
                            dFt = FT_SWFAIL;
                            dNoTgt = 1'b1;
                        end
                    end else if (cfgRng != 6'h00) begin
                        dFwd = 1'b1; // RQ8
                        dPort = lowSel(cfgRng); // RQ23
                        dOvl = cfgMulti;
                    end else begin
                        dFail = 1'b1; // RQ9
                        dFt = FT_SWFAIL;
                        dNoTgt = 1'b1;
                    end
                end else if (!isSpecial) begin
                    dFail = 1'b1; // RQ10
                    dFt = FT_SWFAIL;
                end else if (cfBus == ownPri) begin
                    dEvS = 1'b1; // RQ11
                end else if (spRng != 6'h00) begin
                    dFwd = 1'b1; // RQ12
                    dPort = lowSel(spRng); // RQ23
                    dOvl = spMulti;
                end else if (!ownBusIn) begin
                    dFwd = 1'b1; // RQ12
                end else begin
                    dFail = 1'b1; // RQ12
                    dFt = FT_SWFAIL;
                end
            end
            RG_MEM32, RG_MEM64: begin
                // never claimed locally, only steered to a port
                if (memHit != 6'h00) begin
                    dFwd = 1'b1; // RQ15 RQ16 RQ20
                    dPort = lowSel(memHit); // RQ23
                    dOvl = memMulti;
                end else if (!fromRoot && ownMaster && !ownHit) begin
                    dFwd = 1'b1; // RQ14 RQ16
                end else begin
                    dFail = 1'b1; // RQ15 RQ16
                    dFt = FT_SWFAIL;
                    dEvF = 1'b1;
                    dNoTgt = fromRoot;
                end
            end
            default: begin
                // io decoding lives elsewhere; refuse rather than guess
                dFail = 1'b1;
                dFt = FT_SWFAIL;
            end
        endcase
    end

    wire noTgtSet = hdrValid && dNoTgt;
    wire ovlSet = hdrValid && dOvl;
    wire noTgtClr = apbWr && ownOk && (wIdx == OI_STAT)
        && pwdata[STAT_NOTGT];
    wire ovlClr = apbWr && ownOk && (wIdx == OI_ERR) && pwdata[ERR_OVL];

    // bit 49 is the type flag; clearing it makes a Type1 frame Type0
    wire [49:0] cvtAddr = {1'b0, hdrAddr[48:0]};

    // registers; hardware set wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NOWN; i++) begin
                ownRegs_ff[i] <= RST_VAL;
            end
            for (int q = 0; q < NPORT; q++) begin
                for (int j = 0; j < NPREG; j++) begin
                    portRegs_ff[q][j] <= RST_VAL;
                end
            end
        end else begin
            for (int i = 0; i < NOWN; i++) begin
                if (4'(i) == OI_STAT) begin
                    ownRegs_ff[i][STAT_NOTGT] <= noTgtSet // RQ6 RQ9 RQ15
                        || (ownRegs_ff[i][STAT_NOTGT] && !noTgtClr);
                end else if (4'(i) == OI_ERR) begin
                    ownRegs_ff[i][ERR_OVL] <= ovlSet // RQ23
                        || (ownRegs_ff[i][ERR_OVL] && !ovlClr);
                end else if (apbWr && ownOk && wIdx == 4'(i)) begin
                    ownRegs_ff[i] <= pwdata & OWN_MASK[i];
                end
            end
            for (int q = 0; q < NPORT; q++) begin
                for (int j = 0; j < NPREG; j++) begin
                    if (apbWr && portOk && pIdx == 3'(q) && wIdx == 4'(j)) begin
                        portRegs_ff[q][j] <= pwdata & PRT_MASK[j];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= RST_VAL;
        end else if (apbSetup && !pwrite) begin
            prdata_ff <= rdWord;
        end
    end

    // one registered decision per header
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rtValid_ff <= 1'b0;
            rtForward_ff <= 1'b0;
            rtLocal_ff <= 1'b0;
            rtFail_ff <= 1'b0;
            rtFailType_ff <= FT_NORMAL;
            rtConvert_ff <= 1'b0;
            evSpecial_ff <= 1'b0;
            evRouteFail_ff <= 1'b0;
            rtPort_ff <= 3'h0;
            rtAddr_ff <= 50'h0;
        end else begin
            rtValid_ff <= hdrValid;
            rtForward_ff <= hdrValid && dFwd;
            rtLocal_ff <= hdrValid && dLocal;
            rtFail_ff <= hdrValid && dFail;
            evSpecial_ff <= hdrValid && dEvS;
            evRouteFail_ff <= hdrValid && dEvF;
            if (hdrValid) begin
                rtFailType_ff <= dFt;
                rtConvert_ff <= dConv;
                rtPort_ff <= dPort;
                rtAddr_ff <= dConv ? cvtAddr : hdrAddr; // RQ4
            end
        end
    end

    assign rtValid = rtValid_ff;
    assign rtForward = rtForward_ff;
    assign rtPort = rtPort_ff;
    assign rtLocal = rtLocal_ff;
    assign rtFail = rtFail_ff;
    assign rtFailType = rtFailType_ff;
    assign rtConvert = rtConvert_ff;
    assign rtAddr = rtAddr_ff;
    assign evSpecial = evSpecial_ff;
    assign evRouteFail = evRouteFail_ff;
    assign cfgOverlap = ownRegs_ff[OI_ERR][ERR_OVL];
endmodule

// ===== test/cmr_link_model.sv
// link partner model that delivers frame headers to the decoder
`timescale 1ns/100ps
module cmr_link_model
    import cmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sendReq,
    input wire logic [2:0] sendPort,
    input wire logic [1:0] sendRegion,
    input wire logic sendWrite,
    input wire logic [49:0] sendAddr,
    output logic hdrValid,
    output logic [2:0] hdrInPort,
    output logic [1:0] hdrRegion,
    output logic hdrWrite,
    output logic [49:0] hdrAddr
);
    // idle fields are scrambled so nothing leans on stale values
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hdrValid <= 1'b0;
            {hdrInPort, hdrRegion, hdrWrite, hdrAddr} <= '0;
        end else if (sendReq) begin
            hdrValid <= 1'b1;
            // only 50 bits travel, the upper bits are fabric wide
            hdrAddr <= sendAddr;
            {hdrInPort, hdrRegion, hdrWrite} <= {sendPort, sendRegion, sendWrite};
        end else begin
            hdrValid <= 1'b0;
            {hdrInPort, hdrRegion, hdrWrite, hdrAddr} <=
                ~{hdrInPort, hdrRegion, hdrWrite, hdrAddr};
        end
    end
endmodule

// ===== test/cmr_route_decoder_assertions.sv
// port-level checker for the route decoder
`timescale 1ns/100ps
module cmr_route_decoder_checker
    import cmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hdrValid,
    input wire logic [1:0] hdrRegion,
    input wire logic [49:0] hdrAddr,
    input wire logic rtValid,
    input wire logic rtForward,
    input wire logic [2:0] rtPort,
    input wire logic rtLocal,
    input wire logic rtFail,
    input wire logic rtFailType,
    input wire logic rtConvert,
    input wire logic [49:0] rtAddr,
    input wire logic evSpecial,
    input wire logic evRouteFail
);
    logic [49:0] lastAddr;
    logic [1:0] lastRegion;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lastAddr <= '0;
            lastRegion <= '0;
        end else begin
            lastAddr <= hdrAddr;
            lastRegion <= hdrRegion;
        end
    end
    hdr_answer_a: assert property (hdrValid |=> rtValid)
        else $error("header left without decision");
    one_outcome_a: assert property (
        rtValid |-> $onehot0({rtForward, rtLocal, rtFail}))
        else $error("decision has several outcomes");
    local_type0_a: assert property (rtLocal |->
        lastRegion == RG_CFG && !lastAddr[CF_TYPE])
        else $error("local access not a type0 config frame");
    convert_addr_a: assert property (rtValid && rtConvert |->
        lastAddr[CF_TYPE] && rtAddr == {1'b0, lastAddr[48:0]})
        else $error("converted address wrong");
    dev_port_a: assert property (rtForward && rtConvert |->
        rtPort == lastAddr[13:11] && lastAddr[15:14] == 2'b00)
        else $error("converted frame on wrong port");
    fail_kind_a: assert property (rtFail |-> rtFailType == FT_SWFAIL)
        else $error("failure type not software failure");
    special_normal_a: assert property (evSpecial |->
        !rtForward && !rtFail && rtFailType == FT_NORMAL)
        else $error("special cycle not discarded normally");
    mem_event_a: assert property (evRouteFail |-> rtFail &&
        $past(hdrRegion) inside {RG_MEM32, RG_MEM64})
        else $error("routing event without memory failure");
endmodule
bind cmr_route_decoder cmr_route_decoder_checker cmr_chk_i (.ref_clk,
    .arst_n, .hdrValid, .hdrRegion, .hdrAddr, .rtValid, .rtForward, .rtPort,
    .rtLocal, .rtFail, .rtFailType, .rtConvert, .rtAddr, .evSpecial,
    .evRouteFail);

// ===== test/cmr_route_decoder_tb_top.sv
// self-checking bench for the config and memory route decoder
`timescale 1ns/100ps
module cmr_route_decoder_tb_top import cmr_pkg::*;;
    localparam logic [8:0] LOCAL = 9'b0_000_1_0_0_0_0;
    localparam logic [8:0] FSW = 9'b0_000_0_1_1_0_0;
    localparam logic [8:0] FEV = 9'b0_000_0_1_1_0_1;
    localparam logic [8:0] SPEC = 9'b0_000_0_0_0_1_0;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h23f9;
    logic pready, pslverr, er, sendReq = 1'b0, sendWrite = 1'b0;
    logic [2:0] sendPort = 3'h0, hdrInPort, rtPort;
    logic [1:0] sendRegion = 2'h0, hdrRegion;
    logic [49:0] sendAddr = 50'h0, hdrAddr, rtAddr;
    logic hdrValid, hdrWrite, rtValid, rtForward, rtLocal, rtFail;
    logic rtFailType, rtConvert, evSpecial, evRouteFail, cfgOverlap;
    logic [8:0] seenV, expQ [$];
    int miscompares = 0, total_checks = 0;
    cmr_route_decoder cmr_route_decoder_i (.*);
    cmr_link_model cmr_link_model_i (.*);
    // forwarded port and failure type only mean something in their case
    assign seenV = {rtForward, rtForward ? rtPort : 3'h0, rtLocal, rtFail,
        (rtForward | rtLocal) ? 1'b0 : rtFailType, evSpecial, evRouteFail};
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [49:0] cfg(bit t, int b, int d, int f, int g);
        return {t, 25'h0, b[7:0], d[4:0], f[2:0], g[5:0], 2'b00};
    endfunction
    function automatic logic [8:0] fw(int p);
        return {1'b1, p[2:0], 5'b0};
    endfunction
    task automatic check(string nm, logic [49:0] seen, logic [49:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            check("apb wait", 50'h1, 50'h0);
            results();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic send(int p, logic [1:0] r, bit w, logic [49:0] a,
        logic [8:0] e);
        expQ.push_back(e);
        @(posedge ref_clk);
        {sendReq, sendPort, sendRegion, sendWrite} <= {1'b1, p[2:0], r, w};
        sendAddr <= a;
        @(posedge ref_clk);
        sendReq <= 1'b0;
    endtask
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (rtValid === 1'b1 && expQ.size() == 0)
            check("stray decision", 50'h1, 50'h0);
        else if (rtValid === 1'b1)
            check("decision", 50'(seenV), 50'(expQ.pop_front()));
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        check("watchdog", 50'h1, 50'h0);
        results();
    end
    initial begin
        logic [11:0] wa [7];
        logic [31:0] wd [7];
        logic [31:0] r;
        wa = '{12'h000, 12'h080, 12'h08c, 12'h090, 12'h088, 12'h0c0, 12'h0cc};
        wd = '{32'h0005_0201, 32'h0000_00df, 32'h0004_0300, 32'h10f0_1000,
            32'h0000_0008, 32'h0000_0030, 32'h0007_0600};
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check("bus reset", 50'(rd), 50'h0);
        for (int i = 0; i < 7; i++)
            apb(1'b1, wa[i], wd[i]);
        apb(1'b0, 12'h080, 32'h0);
        check("port state", 50'(rd), 50'h10);
        apb(1'b0, 12'h1c0, 32'h0);
        check("unmapped", 50'({er, rd}), 50'h1_0000_0000);
        for (int i = 0; i < 3; i++) begin
            r = xs();
            send(0, RG_CFG, r[0], cfg(0, r[15:8], r[20:16], r[23:21],
                r[29:24]), LOCAL);
        end
        send(1, RG_CFG, 1'b0, cfg(0, 0, 0, 0, 0), FSW);
        send(0, RG_CFG, 1'b1, cfg(1, 2, 1, 0, 4), fw(1));
        send(0, RG_CFG, 1'b0, cfg(1, 2, 2, 0, 0), FSW);
        apb(1'b0, 12'h020, 32'h0);
        check("no target", 50'(rd), 50'h2000);
        apb(1'b1, 12'h020, 32'h2000);
        apb(1'b0, 12'h020, 32'h0);
        check("no target clr", 50'(rd), 50'h0);
        send(0, RG_CFG, 1'b1, cfg(1, 2, 31, 7, 0), SPEC);
        send(0, RG_CFG, 1'b0, cfg(1, 4, 0, 0, 0), fw(1));
        send(0, RG_CFG, 1'b0, cfg(1, 3, 0, 0, 0), FSW);
        send(1, RG_CFG, 1'b0, cfg(1, 9, 31, 7, 0), FSW);
        send(1, RG_CFG, 1'b1, cfg(1, 1, 31, 7, 0), SPEC);
        send(3, RG_CFG, 1'b1, cfg(1, 3, 31, 7, 0), fw(1));
        send(3, RG_CFG, 1'b1, cfg(1, 9, 31, 7, 0), fw(0));
        send(3, RG_CFG, 1'b1, cfg(1, 5, 31, 7, 0), FSW);
        send(0, RG_MEM32, 1'b1, 50'h1000_0040, FEV);
        apb(1'b1, 12'h084, 32'h2);
        // empty prefetch window so low addresses can only hit video
        apb(1'b1, 12'h094, 32'hfff0_0000);
        send(0, RG_MEM32, 1'b1, 50'h1000_0040, fw(1));
        send(0, RG_MEM32, 1'b1, 50'h000a_0000, fw(1));
        send(0, RG_MEM32, 1'b1, 50'h000b_ffff, fw(1));
        send(0, RG_MEM32, 1'b1, 50'h000c_0000, FEV);
        send(0, RG_MEM32, 1'b1, 50'h2000_0000, FEV);
        send(0, RG_MEM64, 1'b1, 50'h1000_0040, FEV);
        send(3, RG_MEM32, 1'b0, 50'h3000_0000, FEV);
        apb(1'b1, 12'h004, 32'h4);
        send(3, RG_MEM32, 1'b0, 50'h3000_0000, fw(0));
        send(3, RG_MEM32, 1'b1, 50'h1000_0040, fw(1));
        apb(1'b1, 12'h100, 32'h10);
        apb(1'b1, 12'h10c, 32'h0004_0300);
        send(0, RG_CFG, 1'b0, cfg(1, 4, 0, 0, 0), fw(1));
        for (int i = 0; i < 50 && expQ.size() > 0; i++)
            @(posedge ref_clk);
        check("pending", 50'(expQ.size()), 50'h0);
        check("overlap", 50'(cfgOverlap), 50'h1);
        apb(1'b0, 12'h02c, 32'h0);
        check("overlap reg", 50'(rd), 50'h1);
        results();
    end
endmodule
